// ===== rtl/pixel_mode_dac_pan_ctrl.sv
`timescale 1ns/1ns
`default_nettype none

`include "pixel_consts.svh"

module pixel_mode_dac_pan_ctrl
  import pixel_types_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         reset,
  // host port pins, asynchronous to clk
  input  wire logic [1:0]   rs,
  input  wire logic         wr_n,
  input  wire logic         rd_n,
  input  wire logic [7:0]   host_d_in,
  output logic      [7:0]   host_d_out,
  output logic              host_d_oe,
  // pixel port, latched on clk
  input  wire logic         pix_in_valid,
  output logic              pix_in_ready,
  input  wire logic [159:0] pix_in_data,
  input  wire logic [4:0]   pixel_source_select,
  input  wire logic [9:0]   overlay_in,
  input  wire logic         sync_in,
  input  wire logic         blank_in,
  // decoded pixel stream toward the tables
  output logic              pix_out_valid,
  input  wire logic         pix_out_ready,
  output logic      [7:0]   pix_out_pseudo,
  output logic      [7:0]   pix_out_red,
  output logic      [7:0]   pix_out_green,
  output logic      [7:0]   pix_out_blue,
  output logic              pix_out_use_pseudo,
  output logic              pix_out_sync,
  output logic              pix_out_blank,
  output logic      [1:0]   pix_out_overlay,
  // dac controls
  output logic              sync_pedestal_en,
  output logic              blank_pedestal_en,
  output logic              dac_6bit,
  output logic      [1:0]   dac_contrast,
  output logic              dac_force_blank
);

  // ---------------- host port synchronisers ----------------
  logic [11:0] host_meta_reg;   // first stage, feeds only the second
  logic [11:0] host_sync_reg;   // second stage, safe to read
  logic        wr_n_last_reg;   // previous synced write strobe
  logic        rd_n_last_reg;   // previous synced read strobe
  logic [1:0]  rs_s;
  logic [7:0]  d_s;
  logic        wr_n_s;
  logic        rd_n_s;
  logic        wr_pulse;        // write strobe falling edge
  logic        rd_pulse;        // read strobe falling edge

  // two flops on every pin before use
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      host_meta_reg <= 12'hc00;
      host_sync_reg <= 12'hc00;
    end else begin
      host_meta_reg <= {wr_n, rd_n, rs, host_d_in};
      host_sync_reg <= host_meta_reg;
    end
  end

  assign wr_n_s = host_sync_reg[11];
  assign rd_n_s = host_sync_reg[10];
  assign rs_s   = host_sync_reg[9:8];
  assign d_s    = host_sync_reg[7:0];

  // strobe history for edge detection
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_n_last_reg <= 1'b1;
      rd_n_last_reg <= 1'b1;
    end else begin
      wr_n_last_reg <= wr_n_s;
      rd_n_last_reg <= rd_n_s;
    end
  end

  assign wr_pulse = wr_n_last_reg && !wr_n_s;
  assign rd_pulse = rd_n_last_reg && !rd_n_s;

  // ---------------- registers ----------------
  logic [7:0] set_reg;      // selected register set
  logic [7:0] index_reg;    // location within set, unused by single sets
  logic [7:0] pix_fmt_reg;  // pixel_format_control
  logic [7:0] dac_reg;      // dac_output_control
  logic [7:0] pan_reg;      // sync_blank_pan_delay
  logic [7:0] rd_data_reg;  // value driven during a read

  // set and index address registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      set_reg   <= `SET_RESET;
      index_reg <= `INDEX_RESET;
    end else if (wr_pulse) begin
      if (rs_s == `RS_SET) begin
        set_reg <= d_s;
      end
      if (rs_s == `RS_INDEX) begin
        index_reg <= d_s;
      end
    end
  end

  // data register writes; unused high bits never stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pix_fmt_reg <= `PIX_FORMAT_RESET;
      dac_reg     <= `DAC_CTRL_RESET;
      pan_reg     <= `PAN_DELAY_RESET;
    end else if (wr_pulse && rs_s == `RS_DATA) begin
      unique case (set_reg)
        `SET_PIX_FORMAT: pix_fmt_reg <= d_s & `PIX_FORMAT_MASK;
        `SET_DAC_CTRL:   dac_reg     <= d_s & `DAC_CTRL_MASK;
        `SET_PAN_DELAY:  pan_reg     <= d_s & `PAN_DELAY_MASK;
        default: begin
          // other sets belong to blocks outside this one
        end
      endcase
    end
  end

  // read data captured at the read strobe edge
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data_reg <= 8'h00;
    end else if (rd_pulse) begin
      unique case (rs_s)
        `RS_SET:   rd_data_reg <= set_reg;
        `RS_INDEX: rd_data_reg <= index_reg;
        `RS_DATA: begin
          unique case (set_reg)
            `SET_PIX_FORMAT: rd_data_reg <= pix_fmt_reg;
            `SET_DAC_CTRL:   rd_data_reg <= dac_reg;
            `SET_PAN_DELAY:  rd_data_reg <= pan_reg;
            default:         rd_data_reg <= 8'h00;
          endcase
        end
        default:   rd_data_reg <= 8'h00;
      endcase
    end
  end

  assign host_d_out = rd_data_reg;
  assign host_d_oe  = !rd_n_s && !rd_n_last_reg;

  // ---------------- dac control fields ----------------
  assign sync_pedestal_en  = !dac_reg[`DAC_SYNC_BIT];
  assign blank_pedestal_en = !dac_reg[`DAC_BLANK_BIT];
  assign dac_6bit          = dac_reg[`DAC_RES_BIT];
  assign dac_contrast      = dac_reg[`DAC_CONTRAST_LSB +: 2];
  assign dac_force_blank   = (dac_contrast == 2'h3);

  // ---------------- pixel format fields ----------------
  pix_size_e   size_sel;
  pseudo_src_e src_sel;
  logic [2:0]  accel;        // pixels per input word, 1..5

  // reserved size code falls back to 32-bit handling
  assign size_sel = (pix_fmt_reg[1:0] == SIZE_RSVD) ? SIZE_32
                  : pix_size_e'(pix_fmt_reg[1:0]);
  assign src_sel  = pseudo_src_e'(pix_fmt_reg[`PF_SRC_LSB +: 2]);

  // zero is taken as one, values past the lanes are clamped
  always_comb begin
    accel = pix_fmt_reg[`PF_ACCEL_LSB +: 3];
    if (accel == 3'h0) begin
      accel = 3'h1;
    end else if (accel > `MAX_PIXELS) begin
      accel = `MAX_PIXELS;
    end
  end

  // fetch pixel idx of a word at the current size; lanes by table order
  function automatic logic [31:0] pick_pixel(input logic [159:0] w,
                                             input pix_size_e    sz,
                                             input logic [2:0]   idx);
    logic [159:0] sh;
    sh = '0;
    unique case (sz)
      SIZE_8:  sh = w >> ({5'h0, idx} * 8'd8);
      SIZE_16: sh = w >> ({5'h0, idx} * 8'd16);
      default: sh = w >> ({5'h0, idx} * 8'd32);
    endcase
    unique case (sz)
      SIZE_8:  pick_pixel = {24'h0, sh[7:0]};
      SIZE_16: pick_pixel = {16'h0, sh[15:0]};
      default: pick_pixel = sh[31:0];
    endcase
  endfunction

  // ---------------- word latch and pixel serialiser ----------------
  logic [159:0] word_reg;    // latched pixel port lanes
  logic [4:0]   sel_reg;     // per-pixel source select pins
  logic [9:0]   ovl_reg;     // per-pixel overlay pairs
  logic         sync_reg;
  logic         blank_reg;
  logic         word_valid_reg;
  logic [2:0]   idx_reg;     // pixel being emitted from the word
  logic         buf_in_ready;
  logic         advance;     // one pixel moves into the pipeline
  logic         last_pixel;

  assign advance      = word_valid_reg && buf_in_ready;
  assign last_pixel   = (idx_reg == accel - 3'h1);
  assign pix_in_ready = !word_valid_reg || (advance && last_pixel);

  // latch a whole word, then issue accel pixels, one per clk
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_reg       <= '0;
      sel_reg        <= 5'h00;
      ovl_reg        <= 10'h000;
      sync_reg       <= 1'b0;
      blank_reg      <= 1'b0;
      word_valid_reg <= 1'b0;
      idx_reg        <= 3'h0;
    end else begin
      if (pix_in_valid && pix_in_ready) begin
        word_reg       <= pix_in_data;
        sel_reg        <= pixel_source_select;
        ovl_reg        <= overlay_in;
        sync_reg       <= sync_in;
        blank_reg      <= blank_in;
        word_valid_reg <= 1'b1;
        idx_reg        <= 3'h0;
      end else if (advance) begin
        if (last_pixel) begin
          word_valid_reg <= 1'b0;
          idx_reg        <= 3'h0;
        end else begin
          idx_reg <= idx_reg + 3'h1;
        end
      end
    end
  end

  // ---------------- pixel decode ----------------
  logic [31:0] raw;
  logic [1:0]  cur_ovl;
  pixel_s      dec;

  assign raw     = pick_pixel(word_reg, size_sel, idx_reg);
  assign cur_ovl = ovl_reg[idx_reg*2 +: 2];

  // split into pseudo and true fields by pixel size
  always_comb begin
    dec       = '0;
    dec.sync  = sync_reg;
    dec.blank = blank_reg;
    unique case (size_sel)
      SIZE_8: begin
        dec.pseudo     = raw[7:0];
        dec.use_pseudo = 1'b1;
      end
      SIZE_16: begin
        dec.red        = {raw[15:10], 2'h0};
        dec.green      = {raw[9:4], 2'h0};
        dec.blue       = {raw[3:0], 4'h0};
        dec.use_pseudo = 1'b0;
      end
      default: begin
        dec.blue  = raw[15:8];
        dec.green = raw[23:16];
        dec.red   = raw[31:24];
        unique case (src_sel)
          SRC_BLUE:  dec.pseudo = raw[15:8];
          SRC_GREEN: dec.pseudo = raw[23:16];
          SRC_RED:   dec.pseudo = raw[31:24];
          default:   dec.pseudo = raw[7:0];
        endcase
        // pin selects pseudo unless the pseudo value is zero
        dec.use_pseudo = sel_reg[idx_reg] && (dec.pseudo != 8'h00);
      end
    endcase
  end

  // ---------------- pan delay of sync, blank, overlay ----------------
  logic [3:0] hist_reg [`PAN_STAGES];  // past {sync,blank,overlay}, in pixels
  logic [2:0] pan_sel;
  logic [3:0] delayed;
  pixel_s     staged;

  assign pan_sel = pan_reg[2:0];

  // shift one pixel per advance so delay counts pixels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < `PAN_STAGES; i++) begin
        hist_reg[i] <= 4'h0;
      end
    end else if (advance) begin
      hist_reg[0] <= {dec.sync, dec.blank, cur_ovl};
      for (int i = 1; i < `PAN_STAGES; i++) begin
        hist_reg[i] <= hist_reg[i-1];
      end
    end
  end

  // zero pan keeps controls aligned with the pixel
  assign delayed = (pan_sel == 3'h0) ? {dec.sync, dec.blank, cur_ovl}
                                     : hist_reg[pan_sel - 3'h1];

  // overlays follow the picture when bit 3 is high
  always_comb begin
    staged         = dec;
    staged.sync    = delayed[3];
    staged.blank   = delayed[2];
    staged.overlay = pan_reg[`PAN_OVL_BIT] ? cur_ovl : delayed[1:0];
  end

  // ---------------- output buffer ----------------
  pixel_s out_px;

  pixel_skid_buffer #(
    .WIDTH ($bits(pixel_s)),
    .DEPTH (2)
  ) u_out_buf (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (word_valid_reg),
    .in_ready  (buf_in_ready),
    .in_data   (staged),
    .out_valid (pix_out_valid),
    .out_ready (pix_out_ready),
    .out_data  (out_px)
  );

  assign pix_out_pseudo     = out_px.pseudo;
  assign pix_out_red        = out_px.red;
  assign pix_out_green      = out_px.green;
  assign pix_out_blue       = out_px.blue;
  assign pix_out_use_pseudo = out_px.use_pseudo;
  assign pix_out_sync       = out_px.sync;
  assign pix_out_blank      = out_px.blank;
  assign pix_out_overlay    = out_px.overlay;

endmodule

`default_nettype wire

// ===== rtl/pixel_consts.svh
`ifndef PIXEL_CONSTS_SVH
`define PIXEL_CONSTS_SVH

// register select codes on the host port
`define RS_SET           2'h0
`define RS_INDEX         2'h1
`define RS_DATA          2'h2

// register set numbers
`define SET_DAC_CTRL     8'h46
`define SET_PIX_FORMAT   8'h49
`define SET_PAN_DELAY    8'h4a

// implemented widths and write masks
`define DAC_CTRL_MASK    8'h1f
`define PIX_FORMAT_MASK  8'h7f
`define PAN_DELAY_MASK   8'h0f

// reset values
`define DAC_CTRL_RESET   8'h00
`define PIX_FORMAT_RESET 8'h00
`define PAN_DELAY_RESET  8'h00
`define SET_RESET        8'h00
`define INDEX_RESET      8'h00

// field positions
`define PF_SIZE_LSB      0
`define PF_ACCEL_LSB     2
`define PF_SRC_LSB       5
`define DAC_SYNC_BIT     0
`define DAC_BLANK_BIT    1
`define DAC_RES_BIT      2
`define DAC_CONTRAST_LSB 3
`define PAN_OVL_BIT      3

// pixel port geometry
`define PORT_LANES       20
`define PORT_BITS        160
`define MAX_PIXELS       3'h5
`define PAN_STAGES       8

`endif

// ===== rtl/pixel_types_pkg.sv
package pixel_types_pkg;

  // pixel size field encoding
  typedef enum logic [1:0] {
    SIZE_32   = 2'h0,
    SIZE_8    = 2'h1,
    SIZE_16   = 2'h2,
    SIZE_RSVD = 2'h3
  } pix_size_e;

  // pseudo byte source encoding
  typedef enum logic [1:0] {
    SRC_PSEUDO = 2'h0,
    SRC_BLUE   = 2'h1,
    SRC_GREEN  = 2'h2,
    SRC_RED    = 2'h3
  } pseudo_src_e;

  // one decoded pixel on its way to the tables
  typedef struct packed {
    logic [7:0] pseudo;
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic       use_pseudo;
    logic       sync;
    logic       blank;
    logic [1:0] overlay;
  } pixel_s;

endpackage

// ===== rtl/pixel_skid_buffer.sv
`timescale 1ns/1ns
`default_nettype none

// two-entry buffer; a stall downstream fills it and drops in_ready
module pixel_skid_buffer #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];  // entry storage
  logic [PW-1:0]    wr_ptr_reg;       // next entry to fill
  logic [PW-1:0]    rd_ptr_reg;       // oldest entry
  logic [PW:0]      count_reg;        // entries held
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // entry writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + PW'(1);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (PW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (PW+1)'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ===== verif/pixel_ctrl_checker_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// port-level checks of the pixel and dac control block
module pixel_ctrl_checker (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [1:0] rs,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [7:0] host_d_out,
  input wire logic       host_d_oe,
  input wire logic       pix_in_valid,
  input wire logic       pix_in_ready,
  input wire logic       pix_out_valid,
  input wire logic       pix_out_ready,
  input wire logic [7:0] pix_out_pseudo,
  input wire logic       pix_out_sync,
  input wire logic       sync_pedestal_en,
  input wire logic       blank_pedestal_en,
  input wire logic       dac_6bit,
  input wire logic [1:0] dac_contrast,
  input wire logic       dac_force_blank
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // a word taken at the pixel port
  sequence seq_take;
    pix_in_valid && pix_in_ready;
  endsequence
  // a read strobe held low long enough to answer
  sequence seq_rd_held;
    !rd_n [*5];
  endsequence
  // an output pixel held back by the consumer
  sequence seq_stall;
    pix_out_valid && !pix_out_ready;
  endsequence
  AST_FORCE_BLANK: assert property (
    dac_force_blank == (dac_contrast == 2'h3))
    else $error("force blank does not follow contrast");
  AST_DAC_BY_WRITE: assert property (
    $changed({sync_pedestal_en, blank_pedestal_en, dac_6bit, dac_contrast})
    |-> !$past(wr_n) && !$past(wr_n, 2) && $past(rs, 2) == 2'h2)
    else $error("dac control moved without a data write");
  AST_OUT_BY_READ: assert property (
    $changed(host_d_out) |-> !$past(rd_n) && !$past(rd_n, 2))
    else $error("read data moved without a read");
  AST_OE_RISE: assert property (
    $rose(host_d_oe) |-> !$past(rd_n, 2) && !$past(rd_n, 3))
    else $error("bus driven too early");
  AST_OE_ON: assert property (
    seq_rd_held |-> host_d_oe)
    else $error("bus not driven during read");
  AST_OE_IDLE: assert property (
    rd_n [*4] |-> !host_d_oe)
    else $error("bus driven after read ended");
  AST_HOLD: assert property (
    seq_stall |=> pix_out_valid && $stable(pix_out_pseudo) && $stable(pix_out_sync))
    else $error("stalled pixel changed");
  AST_ACCEPT_LAT: assert property (
    seq_take |-> ##[1:3] pix_out_valid)
    else $error("accepted word gave no pixel");
endmodule

bind pixel_mode_dac_pan_ctrl pixel_ctrl_checker pixel_ctrl_checker_i (
  .clk, .reset, .rs, .wr_n, .rd_n, .host_d_out, .host_d_oe, .pix_in_valid,
  .pix_in_ready, .pix_out_valid, .pix_out_ready, .pix_out_pseudo, .pix_out_sync,
  .sync_pedestal_en, .blank_pedestal_en, .dac_6bit, .dac_contrast, .dac_force_blank
);
`default_nettype wire

// ===== verif/host_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
// host cpu: byte accesses on the asynchronous strobe pins
module host_cpu_model (
  input  wire logic       clk,
  input  wire logic       slow,
  output logic      [1:0] rs,
  output logic            wr_n,
  output logic            rd_n,
  output logic      [7:0] host_d_in,
  input  wire logic [7:0] host_d_out,
  input  wire logic       host_d_oe
);
  logic [7:0] drv = 8'h00; // byte the cpu puts on the bus
  initial begin
    rs = 2'h0;
    wr_n = 1'b1;
    rd_n = 1'b1;
  end
  // shared bus: the device wins while it drives
  assign host_d_in = host_d_oe ? host_d_out : drv;
  // strobe low 5 clocks (8 when slow), then high 5 clocks
  task automatic access(input logic r, input logic [1:0] s, input logic [7:0] d,
                        output logic [7:0] q);
    @(negedge clk);
    rs = s;
    drv = r ? ~drv : d; // a released bus shows no stale byte
    if (r) begin
      rd_n = 1'b0;
    end else begin
      wr_n = 1'b0;
    end
    repeat (slow ? 8 : 5) @(posedge clk);
    q = host_d_out;
    @(negedge clk);
    rd_n = 1'b1;
    wr_n = 1'b1;
    drv = ~drv;
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_pixel_mode_dac_pan_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "pixel_consts.svh"
// host register traffic and pixel streams against a queue model
module tb_pixel_mode_dac_pan_ctrl
  import pixel_types_pkg::*;
;
  logic         clk = 1'b0, reset = 1'b1, slow = 1'b0, hold = 1'b0;
  logic [1:0]   rs, pix_out_overlay, dac_contrast;
  logic         wr_n, rd_n, host_d_oe, pix_in_ready, pix_out_valid;
  logic [7:0]   host_d_in, host_d_out, rv;
  logic         pix_in_valid = 1'b0, pix_out_ready = 1'b0, sync_in = 1'b0, blank_in = 1'b0;
  logic [159:0] pix_in_data = '0;
  logic [4:0]   pixel_source_select = '0;
  logic [9:0]   overlay_in = '0;
  logic [7:0]   pix_out_pseudo, pix_out_red, pix_out_green, pix_out_blue;
  logic         pix_out_use_pseudo, pix_out_sync, pix_out_blank;
  logic         sync_pedestal_en, blank_pedestal_en, dac_6bit, dac_force_blank;
  int           err_total = 0, comparisons = 0, n_in = 0, n_out = 0;
  int           seed = 32'h92b0cf93;
  logic [7:0]   preg [3] = '{default: 8'h00}; // dac, format, pan
  logic [7:0]   setc [3] = '{`SET_DAC_CTRL, `SET_PIX_FORMAT, `SET_PAN_DELAY};
  logic [7:0]   mask [3] = '{`DAC_CTRL_MASK, `PIX_FORMAT_MASK, `PAN_DELAY_MASK};
  logic [34:0]  exp_q [$];  // size, use, pseudo, rgb
  logic [3:0]   hist [int]; // sync, blank, overlay per pixel
  logic [34:0]  e, eo;
  logic [3:0]   h;
  logic         rdy;        // consumer ready chosen for the coming edge
  // 40 ns period
  always #20 clk = ~clk;
  pixel_mode_dac_pan_ctrl pixel_mode_dac_pan_ctrl_i (
    .clk, .reset, .rs, .wr_n, .rd_n, .host_d_in, .host_d_out, .host_d_oe,
    .pix_in_valid, .pix_in_ready, .pix_in_data, .pixel_source_select, .overlay_in,
    .sync_in, .blank_in, .pix_out_valid, .pix_out_ready, .pix_out_pseudo,
    .pix_out_red, .pix_out_green, .pix_out_blue, .pix_out_use_pseudo, .pix_out_sync,
    .pix_out_blank, .pix_out_overlay, .sync_pedestal_en, .blank_pedestal_en,
    .dac_6bit, .dac_contrast, .dac_force_blank);
  host_cpu_model host_cpu_model_i (
    .clk, .slow, .rs, .wr_n, .rd_n, .host_d_in, .host_d_out, .host_d_oe);
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // verdict
  task automatic report_and_stop;
    $display("mismatches %0d compares %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one host access
  task automatic acc(input logic r, input logic [1:0] s, input logic [7:0] d);
    host_cpu_model_i.access(r, s, d, rv);
  endtask
  // write a set and mirror it
  task automatic setr(input int i, input logic [7:0] v);
    acc(1'b0, `RS_SET, setc[i]);
    acc(1'b0, `RS_DATA, v);
    preg[i] = v & mask[i];
  endtask
  // read a set back
  task automatic rchk(input logic [7:0] s, input logic [7:0] want);
    acc(1'b0, `RS_SET, s);
    acc(1'b1, `RS_DATA, 8'h00);
    check(rv, want);
  endtask
  // dac outputs against the mirrored control byte
  task automatic check_dac;
    check(sync_pedestal_en, !preg[0][0]);
    check(blank_pedestal_en, !preg[0][1]);
    check(dac_6bit, preg[0][2]);
    check(dac_contrast, preg[0][4:3]);
    check(dac_force_blank, preg[0][4:3] == 2'h3);
  endtask
  // offer one random word and queue its pixels
  task automatic send_word;
    logic [31:0] w;
    logic [7:0]  p;
    int          a;
    @(negedge clk);
    for (int i = 0; i < 5; i++) pix_in_data[i*32+:32] = $random(seed);
    {pixel_source_select, overlay_in, sync_in, blank_in} = 17'($random(seed));
    if (n_in % 3 == 0) pix_in_data[8*preg[1][6:5]+:8] = 8'h00; // zero pseudo byte
    pix_in_valid = 1'b1;
    #1;
    for (int k = 0; k < 50 && pix_in_ready !== 1'b1; k++) begin
      @(negedge clk);
      #1;
    end
    check(pix_in_ready, 1'b1);
    a = preg[1][4:2];
    a = (a == 0) ? 1 : (a > 5) ? 5 : a;
    for (int i = 0; i < a; i++) begin
      hist[n_in] = {sync_in, blank_in, overlay_in[2*i+:2]};
      n_in++;
      w = pix_in_data[i*32+:32];
      p = w[8*preg[1][6:5]+:8];
      case (preg[1][1:0])
        SIZE_8: e = {2'h1, 1'b1, pix_in_data[i*8+:8], 24'h0};
        SIZE_16: begin
          w = 32'(pix_in_data[i*16+:16]);
          e = {3'h4, 8'h0, w[15:10], 2'h0, w[9:4], 2'h0, w[3:0], 4'h0};
        end
        default: e = {2'h0, pixel_source_select[i] && p != 8'h00, p, w[31:8]};
      endcase
      exp_q.push_back(e);
    end
    @(posedge clk);
  endtask
  // pick ready; the pixel standing now is the one taken at the next rising edge
  always @(negedge clk) begin
    rdy = !hold && ($random(seed) % 2 == 0);
    if (pix_out_valid === 1'b1 && rdy) begin
      eo = exp_q.pop_front();
      check(pix_out_use_pseudo, eo[32]);
      if (eo[34:33] != 2'h2) check(pix_out_pseudo, eo[31:24]);
      if (eo[34:33] != 2'h1) check({pix_out_red, pix_out_green, pix_out_blue}, eo[23:0]);
      if (preg[2][3]) check(pix_out_overlay, hist[n_out][1:0]);
      if (n_out >= preg[2][2:0]) begin
        h = hist[n_out-preg[2][2:0]];
        check({pix_out_sync, pix_out_blank}, h[3:2]);
        if (!preg[2][3]) check(pix_out_overlay, h[1:0]);
      end
      n_out++;
    end
    pix_out_ready <= rdy;
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check({host_d_oe, pix_out_valid, pix_in_ready}, 3'h1);
    check_dac;
    for (int i = 0; i < 3; i++) rchk(setc[i], 8'h00);
    setr(0, 8'hff); // unused bits set on purpose
    setr(2, 8'hff);
    setr(1, 8'hf9);
    slow = 1'b1;
    for (int i = 0; i < 3; i++) rchk(setc[i], preg[i]);
    slow = 1'b0;
    check_dac;
    acc(1'b0, `RS_SET, 8'h47);
    acc(1'b0, `RS_DATA, 8'h5a);
    rchk(8'h47, 8'h00);
    acc(1'b1, 2'h3, 8'h00);
    check(rv, 8'h00);
    for (int c = 0; c < 4; c++) begin
      setr(0, {3'h0, 2'(c), 3'($random(seed))});
      check_dac;
    end
    for (int r = 0; r < 9; r++) begin
      setr(1, {1'b0, 2'($random(seed)), 3'(r * 3), 2'(r % 3)});
      setr(2, {4'h0, 1'(r % 2), 3'(r)});
      hold = (r == 4);
      fork
        repeat (6) send_word;
        if (hold) begin
          repeat (30) @(negedge clk);
          #1;
          check(pix_in_ready, 1'b0);
          hold = 1'b0;
        end
      join
      @(negedge clk);
      pix_in_valid = 1'b0;
      for (int k = 0; k < 100 && exp_q.size() > 0; k++) @(negedge clk);
      #1;
      check(exp_q.size(), 0);
    end
    report_and_stop;
  end
  // hang guard
  initial begin
    #(40 * 50000);
    err_total++;
    report_and_stop;
  end
endmodule
`default_nettype wire
